// file: hdl/afp_ctrl.v
// Purpose : Fault protection and reset control for a four half-bridge power stage.
// Assumes : All inputs synchronous to clk_in; analog comparators supply fault levels.
// Notes   : Open-drain flags are given as output and output enable pairs.
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.vh"

module afp_ctrl
(
  // Clock and reset.
  input  wire       clk_in,
  input  wire       rst_in,
  // Configuration.
  input  wire [1:0] out_config_in,
  input  wire       three_level_temp_in,
  input  wire       trim_at_regulator_in,
  // Controller reset pin, active low.
  input  wire       reset_n_in,
  // Fault detectors.
  input  wire       temp_over_100_in,
  input  wire       temp_over_125_in,
  input  wire       temp_over_155_in,
  input  wire       supply_undervoltage_in,
  input  wire [3:0] overload_in,
  input  wire [3:0] bootstrap_uv_in,
  input  wire [3:0] short_to_ground_in,
  input  wire [3:0] short_to_supply_in,
  // Half-bridge control.
  output reg  [3:0] bridge_enable_out,
  output reg  [3:0] weak_pulldown_out,
  output reg        amp_ready_out,
  output reg        ext_clock_select_out,
  // Open-drain flags: output level and enable.
  output reg        shutdown_flag_n_out,
  output reg        shutdown_flag_n_oe_out,
  output reg        temp_warning_n_out,
  output reg        temp_warning_n_oe_out,
  output reg        temp_warning_low_n_out,
  output reg        temp_warning_low_n_oe_out,
  output reg        temp_warning_high_n_out,
  output reg        temp_warning_high_n_oe_out
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_GND  = 4'h1;
  localparam [3:0] ST_SUP  = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_RUN  = 4'h8;
  localparam [31:0] STEP_CYC = `AFP_SHORT_STEP_CYC;

  // Maps a set of faulted half-bridges to the set to be turned off.
  function [3:0] afp_off_map;
    input [1:0] cfg;
    input [3:0] err;
    begin
      case (cfg)
        `AFP_CFG_PARALLEL_BRIDGED_CONFIG:
          afp_off_map = (|err) ? 4'hF : 4'h0;
        `AFP_CFG_SE:
          afp_off_map = {{2{err[3]}}, 2'h0}
                      | {1'b0, 1'b0, err[0], err[0]}
                      | {err[1], 2'h0, err[1]};
        default:
          afp_off_map = {{2{err[3] | err[2]}}, {2{err[1] | err[0]}}};
      endcase
    end
  endfunction

  reg  [3:0]  state;
  reg  [31:0] step_cnt;
  reg         reset_n_d;
  reg         thermal_shutdown_fault;
  reg         overload_latch;
  reg  [3:0]  overload_bridges;
  wire [3:0]  local_off;
  wire        global_fault;
  wire        reset_rise;
  wire        running;

  assign reset_rise   = reset_n_in & ~reset_n_d;
  assign running      = (state == ST_RUN);
  assign global_fault = thermal_shutdown_fault | temp_over_155_in | supply_undervoltage_in;
  assign local_off    = afp_off_map(out_config_in, overload_bridges);

  // ----------------------------------------------------------------
  // Startup short check sequence
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state     <= ST_GND;
      step_cnt  <= 32'h0;
      reset_n_d <= 1'b0;
    end
    else
    begin
      reset_n_d <= reset_n_in;
      case (state)
        ST_GND:
        begin
          if (out_config_in == `AFP_CFG_SE)
            state <= ST_RUN;
          else if (|short_to_ground_in)
          begin
            state    <= ST_HOLD;
            step_cnt <= 32'h0;
          end
          else if (step_cnt >= STEP_CYC - 32'h1)
          begin
            state    <= ST_SUP;
            step_cnt <= 32'h0;
          end
          else
            step_cnt <= step_cnt + 32'h1;
        end
        ST_SUP:
        begin
          if (|short_to_supply_in)
          begin
            state    <= ST_HOLD;
            step_cnt <= 32'h0;
          end
          else if (step_cnt >= STEP_CYC - 32'h1)
            state <= ST_RUN;
          else
            step_cnt <= step_cnt + 32'h1;
        end
        ST_HOLD:
        begin
          if (~|(short_to_ground_in | short_to_supply_in))
          begin
            state    <= ST_GND;
            step_cnt <= 32'h0;
          end
        end
        ST_RUN:
          state <= ST_RUN;
        default:
          state <= ST_GND;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault latches
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      thermal_shutdown_fault <= 1'b0;
      overload_latch         <= 1'b0;
      overload_bridges       <= 4'h0;
    end
    else
    begin
      if (temp_over_155_in)
        thermal_shutdown_fault <= 1'b1;
      else if (running && !reset_n_in)
        thermal_shutdown_fault <= 1'b0;
      if (running && (|overload_in))
      begin
        overload_latch   <= 1'b1;
        overload_bridges <= overload_bridges | overload_in;
      end
      else if (running && reset_rise)
      begin
        overload_latch   <= 1'b0;
        overload_bridges <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault summary
  // ----------------------------------------------------------------
  // True when a fault asks for every half-bridge to be Hi-Z.
  function afp_all_off;
    input       global_now;
    input [3:0] overload_now;
    input       overload_held;
    begin
      afp_all_off = global_now | (|overload_now) | overload_held;
    end
  endfunction

  // An overload latch in the cycle of its clear no longer holds the stage off.
  // This keeps the shutdown flag from pulsing after the reset pin rises.
  wire        overload_hold;
  wire        all_off;
  wire [3:0]  bridge_ok;

  assign overload_hold = overload_latch & ~reset_rise;
  assign all_off       = afp_all_off(global_fault, overload_in, overload_hold);

  // ----------------------------------------------------------------
  // Per half-bridge permission
  // ----------------------------------------------------------------
  // A half-bridge may switch unless its group is off or its bootstrap is low.
  genvar hb;
  generate
    for (hb = 0; hb < 4; hb = hb + 1)
    begin : g_bridge
      assign bridge_ok[hb] = ~local_off[hb] & ~bootstrap_uv_in[hb];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next output values
  // ----------------------------------------------------------------
  reg  [3:0]  next_bridge_enable;
  reg  [3:0]  next_weak_pulldown;
  reg         next_amp_ready;
  reg         next_shutdown_oe;
  reg         next_warn_single_oe;
  reg         next_warn_low_oe;
  reg         next_warn_high_oe;

  always @*
  begin
    next_bridge_enable  = 4'h0;
    next_weak_pulldown  = 4'h0;
    next_amp_ready      = 1'b0;
    next_shutdown_oe    = 1'b1;
    next_warn_single_oe = ~three_level_temp_in & temp_over_125_in;
    next_warn_low_oe    = three_level_temp_in & temp_over_100_in;
    next_warn_high_oe   = three_level_temp_in & temp_over_125_in;
    if (!running)
    begin
      next_shutdown_oe = 1'b1;
    end
    else if (!reset_n_in)
    begin
      next_shutdown_oe = 1'b0;
      if (out_config_in != `AFP_CFG_SE)
      begin
        next_weak_pulldown = 4'hF;
      end
    end
    else if (all_off)
    begin
      next_shutdown_oe = 1'b1;
    end
    else
    begin
      next_bridge_enable = bridge_ok;
      next_shutdown_oe   = 1'b0;
      next_amp_ready     = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Stage outputs
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bridge_enable_out          <= 4'h0;
      weak_pulldown_out          <= 4'h0;
      amp_ready_out              <= 1'b0;
      ext_clock_select_out       <= 1'b0;
      shutdown_flag_n_oe_out     <= 1'b1;
      temp_warning_n_oe_out      <= 1'b0;
      temp_warning_low_n_oe_out  <= 1'b0;
      temp_warning_high_n_oe_out <= 1'b0;
    end
    else
    begin
      bridge_enable_out          <= next_bridge_enable;
      weak_pulldown_out          <= next_weak_pulldown;
      amp_ready_out              <= next_amp_ready;
      ext_clock_select_out       <= trim_at_regulator_in;
      shutdown_flag_n_oe_out     <= next_shutdown_oe;
      temp_warning_n_oe_out      <= next_warn_single_oe;
      temp_warning_low_n_oe_out  <= next_warn_low_oe;
      temp_warning_high_n_oe_out <= next_warn_high_oe;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain flag levels
  // ----------------------------------------------------------------
  // The pins only ever pull low; their enables carry the information.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shutdown_flag_n_out     <= 1'b0;
      temp_warning_n_out      <= 1'b0;
      temp_warning_low_n_out  <= 1'b0;
      temp_warning_high_n_out <= 1'b0;
    end
    else
    begin
      shutdown_flag_n_out     <= 1'b0;
      temp_warning_n_out      <= 1'b0;
      temp_warning_low_n_out  <= 1'b0;
      temp_warning_high_n_out <= 1'b0;
    end
  end

endmodule // afp_ctrl
`default_nettype wire

// file: include/afp_regs.vh
// Purpose : Constants for the amplifier fault protection controller.
// Assumes : 25 MHz system clock.
// Notes   : Times are given in their own unit, cycle counts derived from them.
`ifndef AFP_REGS_VH
`define AFP_REGS_VH

`define AFP_CLK_HZ            25000000
`define AFP_CFG_BTL           2'h0
`define AFP_CFG_PARALLEL_BRIDGED_CONFIG          2'h1
`define AFP_CFG_SE            2'h2
`define AFP_SHORT_STEP_US     1000
`define AFP_SHORT_STEP_CYC    ((`AFP_SHORT_STEP_US * 25) )
`define AFP_HB_A              0
`define AFP_HB_B              1
`define AFP_HB_C              2
`define AFP_HB_D              3

`endif

// file: sim/afp_ctrl_chk.sv
// Purpose: Port assertions for the fault controller.
// Assumes: One clock domain.
// Notes: Bound to every afp_ctrl instance.
`timescale 1ns/100ps
`default_nettype none
module afp_ctrl_chk (
  input wire logic       clk_in, rst_in, reset_n_in, supply_undervoltage_in,
  input wire logic       three_level_temp_in, trim_at_regulator_in,
  input wire logic       temp_over_100_in, temp_over_125_in, temp_over_155_in,
  input wire logic [1:0] out_config_in,
  input wire logic [3:0] bootstrap_uv_in, overload_in, bridge_enable_out, weak_pulldown_out,
  input wire logic       amp_ready_out, ext_clock_select_out, shutdown_flag_n_out,
  input wire logic       shutdown_flag_n_oe_out, temp_warning_n_out, temp_warning_n_oe_out,
  input wire logic       temp_warning_low_n_oe_out, temp_warning_high_n_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_UV_HIZ: assert property (reset_n_in && supply_undervoltage_in |=>
    bridge_enable_out == 4'h0 && shutdown_flag_n_oe_out) else $error("uv not hiz");
  AST_HOT_HIZ: assert property (reset_n_in && temp_over_155_in |=>
    bridge_enable_out == 4'h0 && shutdown_flag_n_oe_out) else $error("hot not hiz");
  AST_WARN_HI: assert property (three_level_temp_in && temp_over_125_in |=>
    temp_warning_high_n_oe_out) else $error("high warning missing");
  AST_WARN_LO: assert property (three_level_temp_in && temp_over_100_in |=>
    temp_warning_low_n_oe_out) else $error("low warning missing");
  AST_WARN_TWO: assert property (!three_level_temp_in && temp_over_125_in |=>
    temp_warning_n_oe_out) else $error("warning missing");
  AST_BOOT: assert property (bootstrap_uv_in[0] |=> !bridge_enable_out[0])
    else $error("bootstrap bridge on");
  AST_RST_LOW: assert property (amp_ready_out && !reset_n_in |=>
    !shutdown_flag_n_oe_out && bridge_enable_out == 4'h0) else $error("reset not hiz");
  AST_PULLDN: assert property (amp_ready_out && !reset_n_in |=> weak_pulldown_out ==
    ((out_config_in == 2'h2) ? 4'h0 : 4'hF)) else $error("pulldown wrong");
  AST_OD_LVL: assert property (!shutdown_flag_n_out && !temp_warning_n_out)
    else $error("flag level high");
  AST_EXT_CLK: assert property (##1 ext_clock_select_out == $past(trim_at_regulator_in))
    else $error("clock select wrong");
  cover property (|overload_in ##1 shutdown_flag_n_oe_out);
  cover property (|bootstrap_uv_in && amp_ready_out);
  cover property (!reset_n_in && |weak_pulldown_out);
endmodule // afp_ctrl_chk
bind afp_ctrl afp_ctrl_chk chk (.*);
`default_nettype wire

// file: sim/afp_host_model.sv
// Purpose: System controller driving the reset pin.
// Assumes: Flag enable high means flag pulled low.
// Notes: A request holds reset low, then raises it late enough.
`timescale 1ns/100ps
`default_nettype none
module afp_host_model #(parameter int HOLD_CYC = 100000) (
  input wire logic clk_in, flag_oe_in, req_in,
  output var logic reset_n_out
);
  int   age = 0;
  logic prev = 1'b0;
  always @(posedge clk_in) begin
    prev <= flag_oe_in;
    age  <= (flag_oe_in && !prev) ? 0 : age + 1;
  end
  initial begin
    reset_n_out = 1'b1;
    forever begin
      @(posedge clk_in);
      if (req_in) begin
        reset_n_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        while (age < HOLD_CYC) @(posedge clk_in);
        reset_n_out <= 1'b1;
      end
    end
  end
endmodule // afp_host_model
`default_nettype wire

// file: sim/afp_ctrl_tb.sv
// Purpose: Self-checking bench for afp_ctrl.
// Assumes: 25 MHz clock, host model on reset.
// Notes: Startup check takes two full steps.
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.vh"
module afp_ctrl_tb;
  logic clk_in = 0, rst_in = 1, tl = 0, trim = 0, t1 = 0, t2 = 0, t3 = 0, uv = 0, req = 0;
  logic [1:0] cfg = `AFP_CFG_BTL;
  logic [3:0] ovl = 0, boot = 0, br, pd;
  logic rn, rdy, ext, sd, sdoe, tw, twoe, tlo, tloe, thi, thioe;
  int err_total = 0, comparisons = 0, cycles = 0, i, k, b;
  always #20 clk_in = ~clk_in;
  afp_host_model #(.HOLD_CYC(40)) host (.clk_in(clk_in), .flag_oe_in(sdoe), .req_in(req),
    .reset_n_out(rn));
  afp_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .out_config_in(cfg),
    .three_level_temp_in(tl), .trim_at_regulator_in(trim), .reset_n_in(rn),
    .temp_over_100_in(t1), .temp_over_125_in(t2), .temp_over_155_in(t3),
    .supply_undervoltage_in(uv), .overload_in(ovl), .bootstrap_uv_in(boot),
    .short_to_ground_in(4'h0), .short_to_supply_in(4'h0), .bridge_enable_out(br),
    .weak_pulldown_out(pd), .amp_ready_out(rdy), .ext_clock_select_out(ext),
    .shutdown_flag_n_out(sd), .shutdown_flag_n_oe_out(sdoe), .temp_warning_n_out(tw),
    .temp_warning_n_oe_out(twoe), .temp_warning_low_n_out(tlo),
    .temp_warning_low_n_oe_out(tloe), .temp_warning_high_n_out(thi),
    .temp_warning_high_n_oe_out(thioe));
  // ----------------------------------------
  // Checking and closing.
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  function automatic logic [3:0] warn(input logic l, a, h, e);
    return {l & a, l & h, ~l & h, e};
  endfunction
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    b = $urandom(20);
    cfg = $urandom % 2;
    repeat (3) @(posedge clk_in);
    cyc(1); rst_in = 0;
    cyc(5); req = 1; cyc(1); req = 0; cyc(20);
    check({sdoe, rn, br}, 16'h20);
    for (i = 0; i < 55000 && rdy !== 1'b1; i++) cyc(1);
    cyc(2); check({sdoe, br}, 16'h0F);
    for (i = 0; i < 10; i++) begin
      b = (i == 0) ? 15 : $urandom % 16; boot = b; cyc(2);
      check({sdoe, br}, {12'h0, ~b[3:0]});
      boot = 0; cyc(2);
    end
    uv = 1; cyc(2); check({sdoe, br}, 16'h10);
    uv = 0; cyc(2); check({sdoe, br}, 16'h0F);
    for (i = 0; i < 16; i++) begin
      {tl, t1, t2, trim} = $urandom; cyc(2);
      check({tloe, thioe, tl ? 1'b0 : twoe, ext}, warn(tl, t1, t2, trim));
    end
    {tl, t1, t2} = 0;
    for (k = 0; k < 2; k++) begin
      if (k == 0) ovl = 4'h1 << ($urandom % 4); else t3 = 1;
      cyc(2); check({sdoe, br}, 16'h10);
      ovl = 0; t3 = 0; cyc(5); check({sdoe, br}, 16'h10);
      req = 1; cyc(1); req = 0; cyc(3);
      check({sdoe, pd, br}, 16'h0F0);
      for (i = 0; i < 200 && rn !== 1'b1; i++) cyc(1);
      cyc(3); check({sdoe, br}, 16'h0F);
    end
    cfg = `AFP_CFG_SE; cyc(2); req = 1; cyc(1); req = 0; cyc(3);
    check({sdoe, pd, br}, 16'h0);
    tally_and_finish;
  end
endmodule // afp_ctrl_tb
`default_nettype wire
